// ==== core/cfr_output_chain.sv ====
/*
 Output back end: interpolator with fs/4 mixing, soft limiter, gain and
 offset, port demultiplexer and power meter, plus its register file.
 Assumes samples arrive on mclk with valid spaced at least as far apart
 as the interpolation factor, and a register master that never overlaps
 read and write strobes.
*/
module cfr_output_chain #(
    parameter int OUT_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire cfr_pkg::cfr_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Sample streams
    input wire cfr_pkg::cfr_samp_t stage1_in,
    input wire cfr_pkg::cfr_samp_t stage4_out,
    // Converter ports
    output logic [OUT_W-1:0] out_a,
    output logic out_a_valid,
    output logic [OUT_W-1:0] out_b,
    output logic out_b_valid
);
    localparam int SW = 40;

    function automatic logic signed [17:0] sat18(input logic signed [SW-1:0] v);
        if (v > 40'sd131071) begin
            return 18'sd131071;
        end else if (v < -40'sd131072) begin
            return -18'sd131072;
        end
        return v[17:0];
    endfunction

    function automatic logic [36:0] pwr37(input logic signed [17:0] i,
                                          input logic signed [17:0] q);
        logic signed [37:0] s;
        s = 38'(i * i) + 38'(q * q);
        return s[36:0];
    endfunction

    // Register file
    logic [15:0] ctrl_r, iomode_r, tsqd_r, span_r, tscale_r, inner_r, outer_r;
    logic [15:0] result_r, rdata_r;
    logic done_r;
    logic [15:0] gain_r [2];
    logic [15:0] ofs_r [4];
    logic [15:0] coef_r [cfr_pkg::N_COEF];
    logic [15:0] taper_r [cfr_pkg::N_TAPER];
    logic [15:0] inv_r [cfr_pkg::N_INV];
    logic meter_done;
    logic [15:0] meter_avg;

    wire [7:0] coef_idx = reg_req.addr - cfr_pkg::A_COEF_BASE;
    wire [7:0] taper_idx = reg_req.addr - cfr_pkg::A_TAPER_BASE;
    wire [7:0] inv_idx = reg_req.addr - cfr_pkg::A_INV_BASE;
    wire [7:0] ofs_idx = reg_req.addr - cfr_pkg::A_OFS_BASE;
    wire coef_hit = coef_idx < 8'(cfr_pkg::N_COEF);
    wire taper_hit = taper_idx < 8'(cfr_pkg::N_TAPER);
    wire inv_hit = inv_idx < 8'(cfr_pkg::N_INV);
    wire ofs_hit = ofs_idx < 8'h04;
    wire meter_restart = reg_req.wr &&
        (reg_req.addr == cfr_pkg::A_INNER || reg_req.addr == cfr_pkg::A_OUTER);
    wire status_rd = reg_req.rd && reg_req.addr == cfr_pkg::A_STATUS;
    logic [15:0] rd_scalar;
    wire [15:0] rd_mux = coef_hit ? coef_r[coef_idx[5:0]] :
                         taper_hit ? taper_r[taper_idx[3:0]] :
                         inv_hit ? inv_r[inv_idx[4:0]] :
                         ofs_hit ? ofs_r[ofs_idx[1:0]] : rd_scalar;

    always_comb begin
        case (reg_req.addr)
            cfr_pkg::A_CTRL: rd_scalar = ctrl_r;
            cfr_pkg::A_IOMODE: rd_scalar = iomode_r;
            cfr_pkg::A_GAIN0: rd_scalar = gain_r[0];
            cfr_pkg::A_GAIN1: rd_scalar = gain_r[1];
            cfr_pkg::A_INNER: rd_scalar = inner_r;
            cfr_pkg::A_OUTER: rd_scalar = outer_r;
            cfr_pkg::A_RESULT: rd_scalar = result_r;
            cfr_pkg::A_STATUS: rd_scalar = {15'h0000, done_r};
            cfr_pkg::A_TSQD: rd_scalar = tsqd_r;
            cfr_pkg::A_SPAN: rd_scalar = span_r;
            cfr_pkg::A_TSCALE: rd_scalar = tscale_r;
            default: rd_scalar = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            iomode_r <= '0;
            tsqd_r <= '0;
            span_r <= '0;
            tscale_r <= '0;
            inner_r <= cfr_pkg::CNT_RST;
            outer_r <= cfr_pkg::CNT_RST;
            gain_r <= '{default: cfr_pkg::GAIN_RST};
            ofs_r <= '{default: 16'h0000};
            coef_r <= '{default: 16'h0000};
            coef_r[0] <= cfr_pkg::COEF0_RST;
            taper_r <= '{default: 16'h0000};
            inv_r <= '{default: 16'h0000};
        end else if (reg_req.wr) begin
            if (coef_hit) begin
                coef_r[coef_idx[5:0]] <= reg_req.wdata;
            end
            if (taper_hit) begin
                taper_r[taper_idx[3:0]] <= reg_req.wdata;
            end
            if (inv_hit) begin
                inv_r[inv_idx[4:0]] <= reg_req.wdata;
            end
            if (ofs_hit) begin
                ofs_r[ofs_idx[1:0]] <= reg_req.wdata;
            end
            case (reg_req.addr)
                cfr_pkg::A_CTRL: ctrl_r <= reg_req.wdata;
                cfr_pkg::A_IOMODE: iomode_r <= reg_req.wdata;
                cfr_pkg::A_GAIN0: gain_r[0] <= reg_req.wdata;
                cfr_pkg::A_GAIN1: gain_r[1] <= reg_req.wdata;
                cfr_pkg::A_INNER: inner_r <= reg_req.wdata;
                cfr_pkg::A_OUTER: outer_r <= reg_req.wdata;
                cfr_pkg::A_TSQD: tsqd_r <= reg_req.wdata;
                cfr_pkg::A_SPAN: span_r <= reg_req.wdata;
                cfr_pkg::A_TSCALE: tscale_r <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe; done set wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
            result_r <= '0;
            done_r <= 1'b0;
        end else begin
            rdata_r <= reg_req.rd ? rd_mux : 16'h0000;
            if (meter_done) begin
                result_r <= meter_avg;
                done_r <= 1'b1;
            end else if (status_rd) begin
                done_r <= 1'b0;
            end
        end
    end
    assign reg_rdata = rdata_r;

    // Mode decode
    wire two_ch = ctrl_r[cfr_pkg::CTRL_TWO_CH];
    wire interp_en = ctrl_r[cfr_pkg::CTRL_INTERP_EN];
    wire lim_en = ctrl_r[cfr_pkg::CTRL_LIMIT_EN];
    wire cfr_pkg::cfr_imode_t imode =
        cfr_pkg::cfr_imode_t'(ctrl_r[cfr_pkg::CTRL_IMODE_LSB +: 2]);
    wire x4 = ctrl_r[cfr_pkg::CTRL_IMODE_LSB + 1];
    wire real_mode = interp_en && imode != cfr_pkg::IM_X2_CPLX;
    wire [1:0] last_phase = x4 ? 2'h3 : 2'h1;
    wire [2:0] coef_step = x4 ? 3'h1 : 3'h2;

    // Interpolator: 10-sample line, one polyphase output per cycle
    logic signed [17:0] xi_r [cfr_pkg::N_TAPS];
    logic signed [17:0] xq_r [cfr_pkg::N_TAPS];
    logic [1:0] phase_r, mod_r;
    logic busy_r, ich_r;
    cfr_pkg::cfr_samp_t it_r;
    logic signed [17:0] fir_i, fir_q, mix_i;
    wire in_go = stage4_out.valid && interp_en;

    always_comb begin
        logic signed [SW-1:0] ai;
        logic signed [SW-1:0] aq;
        int k;
        k = 0;
        ai = '0;
        aq = '0;
        for (int m = 0; m < cfr_pkg::N_TAPS; m++) begin
            k = 4 * m + int'(phase_r) * int'(coef_step);
            ai = ai + SW'(xi_r[m] * $signed(coef_r[k]));
            aq = aq + SW'(xq_r[m] * $signed(coef_r[k]));
        end
        // First tap is negative unity at reset, so the sum is negated
        fir_i = sat18(-(ai >>> cfr_pkg::COEF_FRAC));
        fir_q = sat18(-(aq >>> cfr_pkg::COEF_FRAC));
        case (mod_r)
            2'h0: mix_i = fir_i;
            2'h1: mix_i = sat18(-SW'(fir_q));
            2'h2: mix_i = sat18(-SW'(fir_i));
            2'h3: mix_i = fir_q;
            default: mix_i = fir_i;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xi_r <= '{default: 18'sd0};
            xq_r <= '{default: 18'sd0};
            phase_r <= '0;
            mod_r <= '0;
            busy_r <= 1'b0;
            ich_r <= 1'b0;
            it_r <= '0;
        end else begin
            if (in_go) begin
                xi_r <= {stage4_out.i, xi_r[0:cfr_pkg::N_TAPS-2]};
                xq_r <= {stage4_out.q, xq_r[0:cfr_pkg::N_TAPS-2]};
                ich_r <= stage4_out.ch;
                phase_r <= '0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                phase_r <= phase_r + 2'h1;
                busy_r <= phase_r != last_phase;
            end
            if (!interp_en) begin
                it_r <= stage4_out;
            end else if (busy_r) begin
                it_r.valid <= 1'b1;
                it_r.ch <= ich_r;
                it_r.i <= real_mode ? mix_i : fir_i;
                it_r.q <= real_mode ? 18'sd0 : fir_q;
                mod_r <= mod_r + 2'h1;
            end else begin
                it_r.valid <= 1'b0;
            end
        end
    end

    // Soft limiter: delay line with per-slot gain, peak judged mid-window
    logic signed [17:0] dli_r [cfr_pkg::MAX_SPAN];
    logic signed [17:0] dlq_r [cfr_pkg::MAX_SPAN];
    logic [16:0] g_r [cfr_pkg::MAX_SPAN];
    logic [cfr_pkg::MAX_SPAN-1:0] dch_r;
    logic [16:0] g_nxt [cfr_pkg::MAX_SPAN];
    cfr_pkg::cfr_samp_t lo_r;
    logic [5:0] span_n, half;
    logic [4:0] inv_sel;
    logic peak;

    always_comb begin
        case (span_r[1:0])
            2'h0: span_n = 6'd5;
            2'h1: span_n = 6'd9;
            2'h2: span_n = 6'd17;
            default: span_n = 6'd33;
        endcase
        half = span_n >> 1;
    end

    wire [36:0] pk_pwr = pwr37(dli_r[half-6'd1], dlq_r[half-6'd1]);
    wire [15:0] pk_hi = pk_pwr[cfr_pkg::PWR_HI_LSB +: 16];
    wire [15:0] excess = (pk_hi - tsqd_r) >> tscale_r[3:0];

    always_comb begin
        logic [16:0] gs;
        logic [16:0] f;
        logic [32:0] p;
        logic [33:0] gp;
        int ti;
        gs = '0;
        f = '0;
        p = '0;
        gp = '0;
        ti = 0;
        peak = lim_en && pk_hi > tsqd_r;
        inv_sel = (excess > 16'(cfr_pkg::INV_MAX)) ? cfr_pkg::INV_MAX : excess[4:0];
        for (int s = 0; s < cfr_pkg::MAX_SPAN; s++) begin
            gs = (s == 0) ? cfr_pkg::ONE_Q15 : g_r[s-1];
            ti = 2 * int'(half) - s;
            ti = (ti < 2 * int'(half) - ti) ? ti : 2 * int'(half) - ti;
            ti = (ti > cfr_pkg::N_TAPER - 1) ? cfr_pkg::N_TAPER - 1 : ti;
            p = 33'(inv_r[inv_sel] * taper_r[ti]) >> cfr_pkg::COEF_FRAC;
            f = (p > 33'(cfr_pkg::ONE_Q15)) ? 17'h0_0000 : cfr_pkg::ONE_Q15 - p[16:0];
            if (peak && s <= 2 * int'(half)) begin
                gp = 34'(gs * f) >> cfr_pkg::COEF_FRAC;
                g_nxt[s] = gp[16:0];
            end else begin
                g_nxt[s] = gs;
            end
        end
    end

    wire signed [SW-1:0] out_li = SW'(dli_r[span_n-6'd1] * $signed({1'b0, g_r[span_n-6'd1]}));
    wire signed [SW-1:0] out_lq = SW'(dlq_r[span_n-6'd1] * $signed({1'b0, g_r[span_n-6'd1]}));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dli_r <= '{default: 18'sd0};
            dlq_r <= '{default: 18'sd0};
            g_r <= '{default: cfr_pkg::ONE_Q15};
            dch_r <= '0;
            lo_r <= '0;
        end else if (!lim_en) begin
            lo_r <= it_r;
        end else begin
            lo_r.valid <= it_r.valid;
            if (it_r.valid) begin
                dli_r <= {it_r.i, dli_r[0:cfr_pkg::MAX_SPAN-2]};
                dlq_r <= {it_r.q, dlq_r[0:cfr_pkg::MAX_SPAN-2]};
                dch_r <= {dch_r[cfr_pkg::MAX_SPAN-2:0], it_r.ch};
                g_r <= g_nxt;
                lo_r.ch <= dch_r[span_n-6'd1];
                lo_r.i <= sat18(out_li >>> cfr_pkg::COEF_FRAC);
                lo_r.q <= sat18(out_lq >>> cfr_pkg::COEF_FRAC);
            end
        end
    end

    // Gain, offset, rounding and format
    function automatic logic [OUT_W-1:0] fmt(input logic signed [17:0] x,
                                             input logic [15:0] g,
                                             input logic [15:0] ofs,
                                             input logic uns);
        logic signed [SW-1:0] v;
        logic signed [17:0] s;
        logic [OUT_W-1:0] r;
        v = SW'(x * $signed(g)) >>> cfr_pkg::GAIN_FRAC;
        v = v + (SW'($signed(ofs)) <<< cfr_pkg::OFS_LSB);
        s = sat18(v);
        v = SW'(s) + (SW'(1) <<< (17 - OUT_W));
        s = sat18(v);
        r = s[17 -: OUT_W];
        r[OUT_W-1] = r[OUT_W-1] ^ uns;
        return r;
    endfunction

    wire uns = iomode_r[cfr_pkg::IO_UNSIGNED];
    wire gch = lo_r.ch && two_ch;
    wire [15:0] lo_gain = gch ? gain_r[1] : gain_r[0];
    wire [15:0] ofs_i = ofs_r[{gch, 1'b0}];
    wire [15:0] ofs_q = real_mode ? 16'h0000 : ofs_r[{gch, 1'b1}];
    logic [OUT_W-1:0] go_i, go_q;
    logic go_v, go_ch;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            go_i <= '0;
            go_q <= '0;
            go_v <= 1'b0;
            go_ch <= 1'b0;
        end else begin
            go_v <= lo_r.valid;
            if (lo_r.valid) begin
                go_ch <= gch;
                go_i <= fmt(lo_r.i, lo_gain, ofs_i, uns);
                go_q <= fmt(lo_r.q, lo_gain, ofs_q, uns);
            end
        end
    end

    // Port demultiplexer
    wire odd_even = real_mode &&
        iomode_r[cfr_pkg::IO_DEMUX_LSB +: 2] == cfr_pkg::IO_ODD_EVEN;
    logic side_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_a <= '0;
            out_b <= '0;
            out_a_valid <= 1'b0;
            out_b_valid <= 1'b0;
            side_r <= 1'b0;
        end else begin
            out_a_valid <= 1'b0;
            out_b_valid <= 1'b0;
            if (go_v && odd_even) begin
                side_r <= !side_r;
                if (side_r) begin
                    out_b <= go_i;
                    out_b_valid <= 1'b1;
                end else begin
                    out_a <= go_i;
                    out_a_valid <= 1'b1;
                end
            end else if (go_v && real_mode) begin
                if (go_ch) begin
                    out_b <= go_i;
                    out_b_valid <= 1'b1;
                end else begin
                    out_a <= go_i;
                    out_a_valid <= 1'b1;
                end
            end else if (go_v) begin
                out_a <= go_i;
                out_b <= go_q;
                out_a_valid <= 1'b1;
                out_b_valid <= 1'b1;
            end
        end
    end

    // Power meter
    wire cfr_pkg::cfr_samp_t msrc = outer_r[cfr_pkg::OUTER_SRC] ? stage4_out : stage1_in;
    wire take = msrc.valid && (!two_ch || msrc.ch == outer_r[cfr_pkg::OUTER_CH]);
    wire [36:0] m_pwr = pwr37(msrc.i, msrc.q);
    localparam int AW = cfr_pkg::ACC_W;
    logic [AW-1:0] acc_r;
    wire [AW-1:0] m_sum = acc_r + AW'(m_pwr[cfr_pkg::PWR_HI_LSB +: 16]);
    logic [29:0] cnt_r;
    logic [4:0] inner_log, outer_log, tot_log;

    always_comb begin
        inner_log = 5'(4 * (int'(inner_r[0]) + int'(inner_r[1]) +
                    int'(inner_r[2]) + int'(inner_r[3])));
        outer_log = '0;
        for (int b = 0; b < cfr_pkg::OUTER_CNT_W; b++) begin
            if (outer_r[b]) begin
                outer_log = 5'(b);
            end
        end
        tot_log = inner_log + outer_log;
    end

    wire [29:0] cnt_last = 30'((64'd1 << tot_log) - 64'd1);
    wire [AW-1:0] avg_full = m_sum >> tot_log;
    assign meter_done = take && cnt_r == cnt_last && !meter_restart;
    assign meter_avg = avg_full[15:0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
            cnt_r <= '0;
        end else if (meter_restart || meter_done) begin
            acc_r <= '0;
            cnt_r <= '0;
        end else if (take) begin
            acc_r <= m_sum;
            cnt_r <= cnt_r + 30'd1;
        end
    end
endmodule

// ==== core/cfr_pkg.sv ====
/*
 Shared constants, field positions and carrier types of the output chain.
 Assumes a single core clock and a plain register port with byte-wide address.
*/
package cfr_pkg;
    localparam logic [7:0] A_CTRL = 8'h03;
    localparam logic [7:0] A_IOMODE = 8'h09;
    localparam logic [7:0] A_GAIN0 = 8'h40;
    localparam logic [7:0] A_GAIN1 = 8'h41;
    localparam logic [7:0] A_OFS_BASE = 8'h42;
    localparam logic [7:0] A_INNER = 8'h50;
    localparam logic [7:0] A_OUTER = 8'h51;
    localparam logic [7:0] A_RESULT = 8'h52;
    localparam logic [7:0] A_STATUS = 8'h53;
    localparam logic [7:0] A_COEF_BASE = 8'h82;
    localparam logic [7:0] A_TAPER_BASE = 8'hc2;
    localparam logic [7:0] A_TSQD = 8'hd2;
    localparam logic [7:0] A_SPAN = 8'hd3;
    localparam logic [7:0] A_TSCALE = 8'hd4;
    localparam logic [7:0] A_INV_BASE = 8'he0;
    localparam int CTRL_TWO_CH = 0;
    localparam int CTRL_INTERP_EN = 4;
    localparam int CTRL_LIMIT_EN = 5;
    localparam int CTRL_IMODE_LSB = 6;
    localparam int IO_UNSIGNED = 0;
    localparam int IO_DEMUX_LSB = 2;
    localparam logic [1:0] IO_ODD_EVEN = 2'h3;
    localparam int OUTER_SRC = 15;
    localparam int OUTER_CH = 14;
    localparam int OUTER_CNT_W = 14;
    localparam int N_COEF = 40;
    localparam int N_TAPS = 10;
    localparam int N_TAPER = 16;
    localparam int N_INV = 32;
    localparam int MAX_SPAN = 33;
    localparam logic [4:0] INV_MAX = 5'h1f;
    localparam int COEF_FRAC = 15;
    localparam int GAIN_FRAC = 13;
    localparam int OFS_LSB = 2;
    localparam int PWR_HI_LSB = 21;
    localparam int ACC_W = 40;
    localparam logic [16:0] ONE_Q15 = 17'h0_8000;
    localparam logic [15:0] COEF0_RST = 16'h8000;
    localparam logic [15:0] GAIN_RST = 16'h2000;
    localparam logic [15:0] CNT_RST = 16'h0001;
    typedef enum logic [1:0] {
        IM_X2_REAL = 2'h0,
        IM_X2_CPLX = 2'h1,
        IM_X4_REAL = 2'h3
    } cfr_imode_t;
    typedef struct packed {
        logic valid;
        logic ch;
        logic signed [17:0] i;
        logic signed [17:0] q;
    } cfr_samp_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } cfr_reg_req_t;
endpackage

// ==== dv/cfr_output_chain_properties.sv ====
/*
 Port checker of the output chain: register read timing, reset contents,
 readback, bypass latency and odd/even alternation.
 Assumes modes change only while no sample is in flight.
*/
module cfr_output_chain_chk #(
    parameter int OUT_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire cfr_pkg::cfr_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    // Sample streams
    input wire cfr_pkg::cfr_samp_t stage1_in,
    input wire cfr_pkg::cfr_samp_t stage4_out,
    // Converter ports
    input wire logic [OUT_W-1:0] out_a,
    input wire logic out_a_valid,
    input wire logic [OUT_W-1:0] out_b,
    input wire logic out_b_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ctrl_r;
    logic [15:0] io_r;
    logic [39:0] cw_r;
    wire [7:0] cidx = reg_req.addr - cfr_pkg::A_COEF_BASE;
    wire in_coef = reg_req.addr >= cfr_pkg::A_COEF_BASE && reg_req.addr <= 8'ha9;
    wire bypass = !ctrl_r[4] && !ctrl_r[5];
    wire oe = ctrl_r[4] && !ctrl_r[5] && ctrl_r[7:6] != 2'h1 && io_r[3:2] == 2'h3;
    // Shadow of what software wrote
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            io_r <= '0;
            cw_r <= '0;
        end else begin
            if (reg_req.wr && reg_req.addr == cfr_pkg::A_CTRL)
                ctrl_r <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == cfr_pkg::A_IOMODE)
                io_r <= reg_req.wdata;
            if (reg_req.wr && in_coef)
                cw_r[cidx[5:0]] <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_both_out;
        out_a_valid && out_b_valid;
    endsequence
    sequence s_a_then_b;
        out_a_valid && !out_b_valid ##1 out_b_valid && !out_a_valid;
    endsequence
    property p_rdata_idle;
        !reg_req.rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        reg_req.rd && reg_req.addr == 8'haa |=> reg_rdata == 16'h0000;
    endproperty
    property p_coef0_rst;
        reg_req.rd && reg_req.addr == cfr_pkg::A_COEF_BASE && !cw_r[0]
            |=> reg_rdata == 16'h8000;
    endproperty
    property p_coef_rst;
        reg_req.rd && in_coef && cidx != 8'h00 && !cw_r[cidx[5:0]]
            |=> reg_rdata == 16'h0000;
    endproperty
    property p_ctrl_rb;
        reg_req.rd && reg_req.addr == cfr_pkg::A_CTRL |=> reg_rdata == $past(ctrl_r);
    endproperty
    property p_io_rb;
        reg_req.rd && reg_req.addr == cfr_pkg::A_IOMODE |=> reg_rdata == $past(io_r);
    endproperty
    property p_byp_lat;
        stage4_out.valid && bypass |-> ##4 s_both_out;
    endproperty
    property p_oe_alt;
        oe && out_a_valid |-> s_a_then_b;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_coef0_rst: assert property (p_coef0_rst) else $error("first coef reset bad");
    a_coef_rst: assert property (p_coef_rst) else $error("coef reset not zero");
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback bad");
    a_io_rb: assert property (p_io_rb) else $error("io mode readback bad");
    a_byp_lat: assert property (p_byp_lat) else $error("bypass output late");
    a_oe_alt: assert property (p_oe_alt) else $error("odd even order bad");
endmodule

bind cfr_output_chain cfr_output_chain_chk #(.OUT_W(OUT_W)) u_cfr_output_chain_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .stage1_in(stage1_in), .stage4_out(stage4_out), .out_a(out_a),
    .out_a_valid(out_a_valid), .out_b(out_b), .out_b_valid(out_b_valid));

// ==== dv/cfr_dac_model.sv ====
/*
 Converter model that takes samples from both output ports.
 Assumes valid pulses are sampled on the rising edge of mclk.
*/
module cfr_dac_model #(
    parameter int OUT_W = 16
) (
    // Clock
    input wire logic mclk,
    // Converter ports
    input wire logic [OUT_W-1:0] out_a,
    input wire logic out_a_valid,
    input wire logic [OUT_W-1:0] out_b,
    input wire logic out_b_valid,
    // Sample tallies
    output int cnt_a,
    output int cnt_b
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge mclk) begin
        if (out_a_valid === 1'b1)
            cnt_a <= cnt_a + 1;
        if (out_b_valid === 1'b1)
            cnt_b <= cnt_b + 1;
    end
endmodule

// ==== dv/tb_top.sv ====
/*
 Bench of the output chain: register table, bypass gain and offset,
 interpolator modes with port routing, and the power meter.
 Assumes the converter model tallies samples on each port.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { bit chk; logic [15:0] v; } cfr_note_t;
    localparam logic [23:0] RT [10] = '{24'h03_0000, 24'h09_0000, 24'h40_2000,
        24'h82_8000, 24'h83_0000, 24'ha9_0000, 24'haa_0000, 24'h50_0001,
        24'h51_0001, 24'h52_0000};
    localparam logic [47:0] MT [5] = '{48'h0010_000c_0404, 48'h00d0_000c_0808,
        48'h0050_0000_0808, 48'h0010_0000_0800, 48'h0020_0000_0404};
    logic mclk;
    logic rst_n = 1'b0;
    cfr_pkg::cfr_reg_req_t reg_req = '0;
    cfr_pkg::cfr_samp_t s1 = '0;
    cfr_pkg::cfr_samp_t s4 = '0;
    logic [15:0] reg_rdata;
    logic [15:0] out_a;
    logic [15:0] out_b;
    logic out_a_valid;
    logic out_b_valid;
    int cnt_a;
    int cnt_b;
    int fails = 0;
    int num_checks = 0;
    bit chk_out = 0;
    bit rd_d = 0;
    cfr_note_t n;
    logic [31:0] e;
    cfr_note_t rq[$];
    logic [31:0] sq[$];
    cfr_output_chain u_cfr_output_chain (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .stage1_in(s1), .stage4_out(s4), .out_a(out_a),
        .out_a_valid(out_a_valid), .out_b(out_b), .out_b_valid(out_b_valid));
    cfr_dac_model u_cfr_dac_model (.mclk(mclk), .out_a(out_a), .out_a_valid(out_a_valid),
        .out_b(out_b), .out_b_valid(out_b_valid), .cnt_a(cnt_a), .cnt_b(cnt_b));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp16(logic [15:0] got, logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        reg_req <= '0;
    endtask
    task automatic reg_rd(logic [7:0] a, bit c, logic [15:0] x, output logic [15:0] v);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        rq.push_back('{c, x});
        @(posedge mclk);
        reg_req <= '0;
        #1 v = reg_rdata;
    endtask
    // Released data lines show the inverse of the last value
    task automatic send(logic signed [17:0] i, logic signed [17:0] q, int gap);
        @(posedge mclk);
        s4 <= '{valid: 1'b1, ch: 1'b0, i: i, q: q};
        s1 <= '{valid: 1'b1, ch: 1'b0, i: ~i, q: q};
        @(posedge mclk);
        s4 <= '{valid: 1'b0, ch: 1'b0, i: ~i, q: ~q};
        s1 <= '{valid: 1'b0, ch: 1'b0, i: i, q: ~q};
        repeat (gap) @(posedge mclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        rd_d <= reg_req.rd;
        if (rd_d) begin
            n = rq.pop_front();
            if (n.chk)
                cmp16(reg_rdata, n.v);
        end
        if (chk_out && out_a_valid === 1'b1) begin
            e = sq.pop_front();
            cmp16(out_a, e[31:16]);
            cmp16(out_b, e[15:0]);
        end
    end
    initial begin
        logic [15:0] v;
        int r;
        int r2;
        int a0;
        int b0;
        logic [39:0] acc;
        logic [36:0] p;
        logic signed [17:0] si;
        logic signed [17:0] sj;
        void'($urandom(45));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (RT[k]) reg_rd(RT[k][23:16], 1, RT[k][15:0], v);
        reg_wr(8'haa, 16'h1234);
        reg_wr(cfr_pkg::A_RESULT, 16'hffff);
        reg_wr(8'h96, 16'h8000);
        reg_rd(8'h96, 1, 16'h8000, v);
        reg_wr(8'h96, 16'h0000);
        reg_rd(8'h96, 1, 16'h0000, v);
        reg_rd(8'haa, 1, 16'h0000, v);
        reg_rd(cfr_pkg::A_RESULT, 1, 16'h0000, v);
        reg_wr(cfr_pkg::A_GAIN0, 16'h4000);
        reg_wr(cfr_pkg::A_OFS_BASE, 16'h0005);
        reg_wr(cfr_pkg::A_OFS_BASE + 8'h01, 16'hfffd);
        reg_rd(cfr_pkg::A_GAIN0, 1, 16'h4000, v);
        chk_out = 1;
        for (int k = 0; k < 8; k++) begin
            r = int'($urandom_range(16000)) - 8000;
            r2 = int'($urandom_range(16000)) - 8000;
            sq.push_back({16'(2 * r + 5), 16'(2 * r2 - 3)});
            send(18'(4 * r), 18'(4 * r2), 1);
        end
        repeat (10) @(posedge mclk);
        #1 chk_out = 0;
        cmp16(16'(sq.size()), 16'h0000);
        foreach (MT[k]) begin
            reg_wr(cfr_pkg::A_CTRL, MT[k][47:32]);
            reg_wr(cfr_pkg::A_IOMODE, MT[k][31:16]);
            reg_rd(cfr_pkg::A_CTRL, 1, MT[k][47:32], v);
            a0 = cnt_a;
            b0 = cnt_b;
            for (int j = 0; j < 4; j++) send(18'h0_1000, 18'h0_0800, 4);
            repeat (40) @(posedge mclk);
            cmp16(16'(cnt_a - a0), 16'(MT[k][15:8]));
            cmp16(16'(cnt_b - b0), 16'(MT[k][7:0]));
        end
        reg_wr(cfr_pkg::A_INNER, 16'h0001);
        reg_wr(cfr_pkg::A_OUTER, 16'h8003);
        reg_rd(cfr_pkg::A_STATUS, 0, 16'h0000, v);
        acc = '0;
        for (int k = 0; k < 32; k++) begin
            si = 18'($urandom);
            sj = 18'($urandom);
            p = si * si + sj * sj;
            acc = acc + 40'(p[36:21]);
            send(si, sj, 1);
        end
        v = 16'h0000;
        for (int t = 0; t < 20 && v[0] !== 1'b1; t++) reg_rd(cfr_pkg::A_STATUS, 0, 16'h0000, v);
        cmp16(16'(v[0]), 16'h0001);
        reg_rd(cfr_pkg::A_RESULT, 1, acc[20:5], v);
        repeat (4) @(posedge mclk);
        end_of_test();
    end
endmodule
